// *** rtcef_capmem.sv ***
// Purpose: six-byte store for the captured calendar snapshot
// Assumes: one write of all bytes at once, one byte read per cycle
// Notes:   read data come out of a register
`timescale 1ns/1ps
module rtcef_capmem #(
  parameter int DEPTH = 6
) (
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic                      wr_all,
  input  wire logic [DEPTH*8-1:0]        wr_data,
  input  wire logic [$clog2(DEPTH)-1:0]  rd_idx,
  output logic      [7:0]                rd_data
);
  logic [7:0] mem_reg [DEPTH];
  // whole snapshot written together so fields never mix
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (reset) begin
        mem_reg[i] <= 8'h00;
      end else if (wr_all) begin
        mem_reg[i] <= wr_data[i*8 +: 8];
      end
    end
  end
  // registered read port
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= (int'(rd_idx) < DEPTH) ? mem_reg[rd_idx] : 8'h00;
    end
  end
endmodule // rtcef_capmem

// *** rtcef_checker.sv ***
// Purpose: port assertions for the capture and flag unit
// Assumes: every register write passes through bus_req
// Notes:   capture irq check stops once a switch-over was seen
`timescale 1ns/1ps
module rtcef_checker (
  input wire logic                  core_clk,
  input wire logic                  reset,
  input wire rtcef_pkg::rtcef_req_s bus_req,
  input wire logic [7:0]            rd_data,
  input wire logic                  pin_level_low,
  input wire logic                  switchover_evt,
  input wire logic                  irq_out_n,
  input wire logic                  tick_pulse
);
  import rtcef_pkg::*;
  // ********
  // write mirror
  // ********
  logic [7:0] ctl1_reg;
  logic [7:0] cap_reg;
  logic [2:0] low_reg;
  logic [2:0] acc_reg;
  logic       sw_reg;
  logic       acc;
  logic [7:0] wa;
  assign acc = (bus_req.wr | bus_req.rd) & (bus_req.addr <= ADDR_CTRL3);
  assign wa  = bus_req.wr ? bus_req.addr : 8'hff;
  // mirror takes writes on the edge the unit takes them
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctl1_reg <= CTRL1_RST;
      cap_reg  <= CAP_RST;
      low_reg  <= 3'h0;
      acc_reg  <= 3'h0;
      sw_reg   <= 1'b0;
    end else begin
      acc_reg <= {acc_reg[1:0], acc};
      sw_reg  <= sw_reg | switchover_evt;
      if (wa == ADDR_CTRL1) ctl1_reg <= bus_req.wdata;
      if (wa == ADDR_CAP_CTL) cap_reg <= bus_req.wdata;
      if (wa == ADDR_FLAGS) low_reg <= bus_req.wdata[2:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // capture event seen while capture may raise the interrupt
  sequence s_level;
    $rose(pin_level_low) && ctl1_reg[BIT_CAP_IE] &&
      !cap_reg[BIT_CAP_OFF] && !sw_reg;
  endsequence
  sequence s_rd(logic [7:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  AST_CAP_IRQ: assert property (s_level |-> ##[1:3] !irq_out_n)
    else $error("capture event raised no interrupt");
  AST_IRQ_RISE: assert property ($rose(irq_out_n) |-> acc || |acc_reg)
    else $error("interrupt released without a flag access");
  AST_TICK_ONE: assert property (tick_pulse |=> !tick_pulse)
    else $error("tick pulse longer than one cycle");
  AST_TICK_EN: assert property (tick_pulse |-> |ctl1_reg[1:0])
    else $error("tick pulse with both tick enables off");
  AST_RST_QUIET: assert property ($fell(reset) |-> irq_out_n)
    else $error("interrupt active straight after reset");
  AST_UNMAPPED: assert property (s_rd(8'h30) |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  AST_CAP_CTL: assert property (s_rd(ADDR_CAP_CTL) |=>
    rd_data[7:6] == cap_reg[7:6]) else $error("capture control readback");
  AST_LOW_BITS: assert property (s_rd(ADDR_FLAGS) |=>
    rd_data[2:0] == low_reg) else $error("flag low bits readback");
endmodule // rtcef_checker
bind rtcef_top rtcef_checker u_chk (
  .core_clk(core_clk), .reset(reset), .bus_req(bus_req),
  .rd_data(rd_data), .pin_level_low(pin_level_low),
  .switchover_evt(switchover_evt), .irq_out_n(irq_out_n),
  .tick_pulse(tick_pulse));

// *** rtcef_host.sv ***
// Purpose: host model on the register port of the unit
// Assumes: called only after reset has been released
// Notes:   turnaround alternates between prompt and slow
`timescale 1ns/1ps
module rtcef_host (
  input  wire logic                  core_clk,
  output rtcef_pkg::rtcef_req_s      bus_req,
  input  wire logic [7:0]            rd_data
);
  import rtcef_pkg::*;
  logic slow = 1'b0;
  // idle bus shows inverted junk, never a stale request
  initial bus_req = '{wr: 1'b0, rd: 1'b0, addr: 8'hff, wdata: 8'hff};
  // one request, held up to the edge that takes it
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [7:0] dw;
    dw = (a == ADDR_FLAGS) ? (d & 8'hbf) : d;
    @(posedge core_clk);
    #1;
    bus_req = '{wr: w, rd: !w, addr: a, wdata: dw};
    @(posedge core_clk);
    #1;
    q = rd_data;
    bus_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~dw};
    slow = !slow;
    // a slow turnaround still ends off the edge, like every other drive
    if (slow) begin
      @(posedge core_clk);
      #1;
    end
  endtask
endmodule // rtcef_host

// *** rtcef_pkg.sv ***
// Purpose: shared constants and types of the capture and flag unit
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   offsets without a printed value are local choices
package rtcef_pkg;
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] ADDR_CTRL1   = 8'h00; // first_control_reg
  localparam logic [7:0] ADDR_FLAGS   = 8'h01; // flag_status
  localparam logic [7:0] ADDR_CTRL3   = 8'h02; // switchover control
  localparam logic [7:0] ADDR_CAP_CTL = 8'h12;
  localparam logic [7:0] ADDR_CAP_SEC = 8'h13;
  localparam logic [7:0] ADDR_CAP_MIN = 8'h14;
  localparam logic [7:0] ADDR_CAP_HR  = 8'h15;
  localparam logic [7:0] ADDR_CAP_DAY = 8'h16;
  localparam logic [7:0] ADDR_CAP_MON = 8'h17;
  localparam logic [7:0] ADDR_CAP_YR  = 8'h18;
  // ****************************************************
  // field positions
  // ****************************************************
  localparam int BIT_SEC_IE   = 0; // per_second_irq_enable
  localparam int BIT_MIN_IE   = 1; // once_per_sixty_s_irq_enable
  localparam int BIT_CAP_IE   = 2; // capture_irq_enable
  localparam int BIT_H12      = 3; // hour_format_select, 1 = 12 hour
  localparam int BIT_TICK     = 7;
  localparam int BIT_WDOG     = 6;
  localparam int BIT_GND      = 5;
  localparam int BIT_ALARM    = 4;
  localparam int BIT_CDOWN    = 3;
  localparam int BIT_LEVEL    = 2; // tamper_level_flag lives in ctrl3
  localparam int BIT_SW_FLAG  = 3;
  localparam int BIT_SW_CAPEN = 5;
  localparam int BIT_KEEP1ST  = 7;
  localparam int BIT_CAP_OFF  = 6;
  localparam logic [7:0] CLEARABLE = 8'hb8; // flag bits software may clear
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CAP_RST   = 8'h00;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_HZ       = 20000000;
  localparam int TICK_HZ      = 64;
  localparam int TICK_DIV     = CLK_HZ / TICK_HZ;
  localparam int TICKS_PER_S  = 64;
  localparam int SEC_PER_MIN  = 60;
  localparam int MEM_DEPTH    = 6;
  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } rtcef_time_s;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtcef_req_s;
  typedef enum logic [1:0] {
    RTCEF_IDLE  = 2'b00,
    RTCEF_LEVEL = 2'b01,
    RTCEF_GND   = 2'b11
  } rtcef_pin_e;
endpackage

// *** rtcef_top.sv ***
// Purpose: event capture, flag register and second/minute ticks
// Assumes: inputs synchronous to core_clk, 8-bit register port
// Notes:   read data appear one cycle after a bus_req read request
//
// How it works
// - second/minute ticks come from a 64 Hz divider, apart from timers.
// - second and minute tick enables are separate bits in control one.
// - flag write ANDs each clearable flag with the written bit.
// - flags: tick 7, watchdog 6, ground 5, alarm 4, countdown 3.
// - rewriting ones or unused bits changes no behaviour.
// - tamper pin sensed for mid-level and for ground separately.
// - capture on after reset; capture_disable switches off tamper capture only.
// - mid-level event captures time, sets level flag, may raise irq.
// - clearing level flag drops irq; re-set only on new falling edge.
// - ground event captures time, sets both flags, may raise irq.
// - irq held until both flags clear; ground flag needs new ground.
// - repeated events keep latest, or earliest when keep_first set.
// - captured seconds BCD, tens bits 6..4, units 3..0.
// - captured minutes BCD, tens bits 6..4, units 3..0.
// - captured hour follows 12/24 format; bit 5 PM in 12 hour.
// - captured day BCD, tens bits 5..4, units 3..0.
// - keep_first and disable live in capture control at 12h.
// - switchover with enable captures once, then freezes capture.
// - captured month BCD, tens bit 4, units 3..0.
// - captured year BCD, tens 7..4, units 3..0.
`timescale 1ns/1ps
module rtcef_top
  import rtcef_pkg::*;
#(
  parameter int TICK_DIVIDE = rtcef_pkg::TICK_DIV
) (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire rtcef_pkg::rtcef_req_s bus_req,
  output logic      [7:0]           rd_data,
  input  wire logic                 pin_level_low,
  input  wire logic                 pin_ground,
  input  wire rtcef_pkg::rtcef_time_s cal_now,
  input  wire logic                 sec_inc,
  input  wire logic                 min_inc,
  input  wire logic                 switchover_evt,
  input  wire logic                 wdog_set,
  input  wire logic                 alarm_set,
  input  wire logic                 cdown_set,
  output logic                      irq_out_n,
  output logic                      tick_pulse
);
  import rtcef_pkg::*;

  // ****************************************************
  // registers
  // ****************************************************
  logic [7:0]  ctrl1_reg;
  logic [7:0]  cap_ctl_reg;
  logic        sw_capen_reg;
  logic        sw_flag_reg;
  logic        tick_flag_reg, wdog_reg, gnd_flag_reg, alarm_reg, cdown_reg;
  logic        level_flag_reg;
  logic [2:0]  low_bits_reg;
  rtcef_pin_e  pin_state_reg;
  logic [$clog2(TICK_DIVIDE+1)-1:0] div_reg;
  logic        sec_pend_reg, min_pend_reg;
  logic [7:0]  dir_rd_reg;
  logic        use_mem_reg;
  logic [7:0]  mem_rd;
  logic [2:0]  mem_idx;
  logic        wr_flags, wr_c1, wr_c3, wr_cap;
  logic        ev_level, ev_gnd, ev_any, pin_ev_ok, do_capture;
  logic        cap_busy;
  logic [47:0] snap;
  logic [7:0]  hour_cap;

  assign wr_flags = bus_req.wr && (bus_req.addr == ADDR_FLAGS);
  assign wr_c1    = bus_req.wr && (bus_req.addr == ADDR_CTRL1);
  assign wr_c3    = bus_req.wr && (bus_req.addr == ADDR_CTRL3);
  assign wr_cap   = bus_req.wr && (bus_req.addr == ADDR_CAP_CTL);

  // keep only the fields that the BCD layouts allow
  function automatic logic [7:0] fmt_hour(input logic [7:0] h,
                                          input logic h12);
    fmt_hour = h12 ? {2'b00, h[5], h[4], h[3:0]}
                   : {2'b00, h[5:4], h[3:0]};
  endfunction

  // ****************************************************
  // control registers
  // ****************************************************
  // control one: tick enables, capture irq enable, hour format
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl1_reg <= CTRL1_RST;
    end else if (wr_c1) begin
      ctrl1_reg <= bus_req.wdata;
    end
  end

  // capture control keeps only its two defined bits so unused bits read 0
  // capture control: keep_first and disable, default capture on
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cap_ctl_reg <= CAP_RST;
    end else if (wr_cap) begin
      cap_ctl_reg <= bus_req.wdata & 8'hc0;
    end
  end

  // switchover capture enable
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sw_capen_reg <= 1'b0;
    end else if (wr_c3) begin
      sw_capen_reg <= bus_req.wdata[BIT_SW_CAPEN];
    end
  end

  // ****************************************************
  // 64 Hz base and second/minute ticks
  // ****************************************************
  // own divider so the ticks never depend on the timer clocks
  // the watchdog and countdown logic may stop or reload its own clock
  // at any time; sharing that base would stretch or drop tick pulses
  always_ff @(posedge core_clk) begin
    if (reset) begin
      div_reg <= '0;
    end else if (int'(div_reg) >= TICK_DIVIDE - 1) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // an increment is held until the next 64 Hz edge, so a tick can lag
  // the calendar by up to one 64 Hz period; that is the price of one base
  // counter increments are latched and released on the 64 Hz edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sec_pend_reg <= 1'b0;
      min_pend_reg <= 1'b0;
      tick_pulse   <= 1'b0;
    end else begin
      if (int'(div_reg) >= TICK_DIVIDE - 1) begin
        sec_pend_reg <= sec_inc;
        min_pend_reg <= min_inc;
        tick_pulse   <= (sec_pend_reg && ctrl1_reg[BIT_SEC_IE]) ||
                        (min_pend_reg && ctrl1_reg[BIT_MIN_IE]);
      end else begin
        sec_pend_reg <= sec_pend_reg | sec_inc;
        min_pend_reg <= min_pend_reg | min_inc;
        tick_pulse   <= 1'b0;
      end
    end
  end

  // ****************************************************
  // tamper pin sensing
  // ****************************************************
  // limitation: the pin is seen as two ready-made comparator levels;
  // a level that bounces between them makes a fresh edge every time
  // ground implies mid-level too; edges are state changes upward
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_state_reg <= RTCEF_IDLE;
    end else begin
      case ({pin_ground, pin_level_low})
        2'b00:   pin_state_reg <= RTCEF_IDLE;
        2'b01:   pin_state_reg <= RTCEF_LEVEL;
        default: pin_state_reg <= RTCEF_GND;
      endcase
    end
  end

  assign ev_gnd    = pin_ground && (pin_state_reg != RTCEF_GND);
  assign ev_level  = pin_level_low && !pin_ground &&
                     (pin_state_reg == RTCEF_IDLE);
  assign pin_ev_ok = !cap_ctl_reg[BIT_CAP_OFF] && !sw_flag_reg;
  assign ev_any    = pin_ev_ok && (ev_gnd || ev_level);
  assign cap_busy  = level_flag_reg || gnd_flag_reg;
  // keep_first blocks tamper reloads while a capture flag stands; switchover capture ignores it
  assign do_capture = (ev_any &&
                       !(cap_ctl_reg[BIT_KEEP1ST] && cap_busy)) ||
                      (switchover_evt && sw_capen_reg && !sw_flag_reg);

  // ****************************************************
  // flag register
  // ****************************************************
  // a host that writes ones to every flag it is not clearing can never
  // lose an event, because the set term is ORed after the AND
  // hardware sets win over the AND-clear of a concurrent write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tick_flag_reg <= 1'b0;
      gnd_flag_reg  <= 1'b0;
      alarm_reg     <= 1'b0;
      cdown_reg     <= 1'b0;
      low_bits_reg  <= 3'h0;
    end else begin
      tick_flag_reg <= ((wr_flags ? bus_req.wdata[BIT_TICK] : 1'b1) &
                        tick_flag_reg) |
                       ((sec_inc && ctrl1_reg[BIT_SEC_IE]) ||
                        (min_inc && ctrl1_reg[BIT_MIN_IE]));
      gnd_flag_reg  <= ((wr_flags ? bus_req.wdata[BIT_GND] : 1'b1) &
                        gnd_flag_reg) | (ev_any && ev_gnd);
      alarm_reg     <= ((wr_flags ? bus_req.wdata[BIT_ALARM] : 1'b1) &
                        alarm_reg) | alarm_set;
      cdown_reg     <= ((wr_flags ? bus_req.wdata[BIT_CDOWN] : 1'b1) &
                        cdown_reg) | cdown_set;
      if (wr_flags) begin
        low_bits_reg <= bus_req.wdata[2:0]; // stored only, no effect
      end
    end
  end

  // writes are ignored on purpose: a host following the clear recipe
  // writes 0 here and must not lose a pending watchdog event
  // watchdog flag is set by its timer, a flag write never touches it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wdog_reg <= 1'b0;
    end else if (wdog_set) begin
      wdog_reg <= 1'b1;
    end else if (bus_req.rd && bus_req.addr == ADDR_FLAGS) begin
      wdog_reg <= 1'b0;
    end
  end

  // level flag and switchover flag sit in control three
  always_ff @(posedge core_clk) begin
    if (reset) begin
      level_flag_reg <= 1'b0;
      sw_flag_reg    <= 1'b0;
    end else begin
      level_flag_reg <= ((wr_c3 ? bus_req.wdata[BIT_LEVEL] : 1'b1) &
                         level_flag_reg) | ev_any;
      sw_flag_reg    <= ((wr_c3 ? bus_req.wdata[BIT_SW_FLAG] : 1'b1) &
                         sw_flag_reg) |
                        (switchover_evt && sw_capen_reg);
    end
  end

  // ****************************************************
  // capture snapshot
  // ****************************************************
  // the calendar may carry between fields on any edge; sampling all six
  // bytes from one vector in one cycle keeps a carry from splitting them
  // one vector from the same cycle feeds every byte
  assign hour_cap = fmt_hour(cal_now.hour, ctrl1_reg[BIT_H12]);
  assign snap = {cal_now.year,
                 {3'h0, cal_now.month[4:0]},
                 {2'h0, cal_now.day[5:0]},
                 hour_cap,
                 {1'b0, cal_now.minute[6:0]},
                 {1'b0, cal_now.second[6:0]}};
  assign mem_idx = 3'(bus_req.addr - ADDR_CAP_SEC);

  rtcef_capmem #(
    .DEPTH   (MEM_DEPTH)
  ) u_mem (
    .core_clk (core_clk),
    .reset    (reset),
    .wr_all   (do_capture),
    .wr_data  (snap),
    .rd_idx   (mem_idx),
    .rd_data  (mem_rd)
  );

  // ****************************************************
  // read port and interrupt
  // ****************************************************
  // trade-off: the memory keeps its own read register, so the output is
  // a select between two flops rather than a third register; this keeps
  // the read answer one cycle after the request
  // direct registers are muxed beside the memory's registered port
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dir_rd_reg  <= 8'h00;
      use_mem_reg <= 1'b0;
    end else begin
      use_mem_reg <= (bus_req.addr >= ADDR_CAP_SEC) &&
                     (bus_req.addr <= ADDR_CAP_YR);
      case (bus_req.addr)
        ADDR_CTRL1:   dir_rd_reg <= ctrl1_reg;
        ADDR_FLAGS:   dir_rd_reg <= {tick_flag_reg, wdog_reg, gnd_flag_reg,
                                     alarm_reg, cdown_reg,
                                     low_bits_reg};
        ADDR_CTRL3:   dir_rd_reg <= {2'b00, sw_capen_reg, 1'b0,
                                     sw_flag_reg, level_flag_reg, 2'b00};
        ADDR_CAP_CTL: dir_rd_reg <= cap_ctl_reg;
        default:      dir_rd_reg <= 8'h00;
      endcase
    end
  end

  assign rd_data = use_mem_reg ? mem_rd : dir_rd_reg;

  // the ground flag alone keeps the line low, so clearing only the level
  // flag after a ground event does not release the interrupt
  // interrupt follows the capture flags until both are cleared
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= !(ctrl1_reg[BIT_CAP_IE] &&
                     (level_flag_reg || gnd_flag_reg));
    end
  end
endmodule // rtcef_top

// *** tb.sv ***
// Purpose: self-checking bench for the capture and flag unit
// Assumes: tick divider shortened to 8 clocks
// Notes:   calendar values are random but always legal BCD
`timescale 1ns/1ps
module tb;
  import rtcef_pkg::*;
  localparam logic [47:0] MASK = 48'hff1f3f3f7f7f;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  rtcef_req_s  bus_req;
  logic [7:0]  rd_data;
  logic        pin_level_low = 1'b0;
  logic        pin_ground = 1'b0;
  rtcef_time_s cal_now = '0;
  rtcef_time_s t1;
  logic [5:0]  evt = '0;
  logic        irq_out_n;
  logic        tick_pulse;
  logic        h12;
  logic [7:0]  q;
  int          n_fail = 0;
  int          checks_done = 0;
  int          seed = 32'h46a6;
  rtcef_top #(.TICK_DIVIDE(8)) u_dut (
    .core_clk(core_clk), .reset(reset), .bus_req(bus_req),
    .rd_data(rd_data), .pin_level_low(pin_level_low),
    .pin_ground(pin_ground), .cal_now(cal_now), .sec_inc(evt[0]),
    .min_inc(evt[1]), .switchover_evt(evt[2]), .wdog_set(evt[3]),
    .alarm_set(evt[4]), .cdown_set(evt[5]), .irq_out_n(irq_out_n),
    .tick_pulse(tick_pulse));
  rtcef_host u_host (.core_clk(core_clk), .bus_req(bus_req),
                     .rd_data(rd_data));
  always #25 core_clk = ~core_clk;
  // ********
  // helpers
  // ********
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, m, e);
    u_host.xfer(1'b0, a, 8'h00, q);
    chk(q & m, e);
  endtask
  task automatic wr(input logic [7:0] a, d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic pulse(input int b);
    @(posedge core_clk);
    #1;
    evt[b] = 1'b1;
    @(posedge core_clk);
    #1;
    evt = '0;
  endtask
  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction
  function automatic logic [7:0] bcd(input int n);
    return 8'((n / 10) * 16 + n % 10);
  endfunction
  // 12 hour mode puts the pm marker on bit 5
  task automatic new_time(input logic h);
    logic [7:0] hr;
    hr = h ? (bcd(1 + rnd(12)) | 8'(rnd(2) * 32)) : bcd(rnd(24));
    cal_now = {bcd(rnd(100)), bcd(1 + rnd(12)), bcd(1 + rnd(28)),
               hr, bcd(rnd(60)), bcd(rnd(60))};
  endtask
  // pin held a few clocks, then released to the pulled-up idle level
  task automatic tamper(input logic g);
    @(posedge core_clk);
    #1;
    pin_level_low = 1'b1;
    pin_ground = g;
    repeat (4) @(posedge core_clk);
    #1;
    pin_level_low = 1'b0;
    pin_ground = 1'b0;
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge core_clk);
    #1;
    chk({7'h0, irq_out_n}, {7'h0, e});
  endtask
  task automatic tick_wait(input logic e);
    logic got;
    got = 1'b0;
    repeat (30) begin
      @(posedge core_clk);
      #1;
      if (tick_pulse === 1'b1) got = 1'b1;
    end
    chk({7'h0, got}, {7'h0, e});
  endtask
  task automatic cap_chk(input rtcef_time_s t);
    for (int i = 0; i < 6; i++)
      rd(ADDR_CAP_SEC + 8'(i), 8'hff, t[8*i +: 8] & MASK[8*i +: 8]);
  endtask
  task automatic wrap_up();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // hang guard, far beyond the few hundred clocks of the run
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    wrap_up();
  end
  // ********
  // scenarios
  // ********
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    reset = 1'b0;
    rd(ADDR_CAP_CTL, 8'hc0, 8'h00);
    rd(8'h30, 8'hff, 8'h00);
    for (int b = 3; b < 6; b++) pulse(b);
    wr(ADDR_FLAGS, 8'hf0);
    rd(ADDR_FLAGS, 8'hff, 8'h50);
    rd(ADDR_FLAGS, 8'hff, 8'h10);
    wr(ADDR_FLAGS, 8'h17);
    wr(ADDR_FLAGS, 8'h17);
    rd(ADDR_FLAGS, 8'hff, 8'h17);
    wr(ADDR_FLAGS, 8'h07);
    rd(ADDR_FLAGS, 8'hff, 8'h07);
    wr(ADDR_CTRL1, 8'h01);
    wr(ADDR_FLAGS, 8'h00);
    pulse(0);
    tick_wait(1'b1);
    rd(ADDR_FLAGS, 8'h80, 8'h80);
    wr(ADDR_CTRL1, 8'h02);
    wr(ADDR_FLAGS, 8'h00);
    pulse(0);
    tick_wait(1'b0);
    pulse(1);
    tick_wait(1'b1);
    wr(ADDR_FLAGS, 8'h00);
    // two events per round, the later one must be kept
    for (int k = 0; k < 4; k++) begin
      h12 = 1'(rnd(2)) & (k != 0);
      wr(ADDR_CTRL1, {4'h0, h12, 3'b100});
      new_time(h12);
      tamper(1'b0);
      if (k == 0) cal_now = {8'h99, 8'h12, 8'h31, 8'h23, 8'h59, 8'h59};
      else new_time(h12);
      t1 = cal_now;
      tamper(1'b0);
      new_time(h12);
      irq_is(1'b0);
      rd(ADDR_CTRL3, 8'h04, 8'h04);
      cap_chk(t1);
      wr(ADDR_CTRL3, 8'h00);
      irq_is(1'b1);
    end
    t1 = cal_now;
    tamper(1'b1);
    new_time(1'b0);
    rd(ADDR_FLAGS, 8'h20, 8'h20);
    rd(ADDR_CTRL3, 8'h04, 8'h04);
    cap_chk(t1);
    wr(ADDR_CTRL3, 8'h00);
    irq_is(1'b0);
    wr(ADDR_FLAGS, 8'h00);
    irq_is(1'b1);
    wr(ADDR_CAP_CTL, 8'h80);
    t1 = cal_now;
    tamper(1'b0);
    new_time(1'b0);
    tamper(1'b0);
    cap_chk(t1);
    wr(ADDR_CTRL3, 8'h00);
    wr(ADDR_CAP_CTL, 8'h40);
    new_time(1'b0);
    tamper(1'b0);
    rd(ADDR_CTRL3, 8'h04, 8'h00);
    cap_chk(t1);
    wr(ADDR_CAP_CTL, 8'h00);
    wr(ADDR_CTRL3, 8'h20);
    t1 = cal_now;
    pulse(2);
    new_time(1'b0);
    rd(ADDR_CTRL3, 8'h08, 8'h08);
    tamper(1'b0);
    rd(ADDR_CTRL3, 8'h04, 8'h00);
    cap_chk(t1);
    // mid-run reset, then a pin held low across the flag clear
    @(posedge core_clk);
    #1;
    reset = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    reset = 1'b0;
    @(posedge core_clk);
    #1;
    pin_level_low = 1'b1;
    repeat (3) @(posedge core_clk);
    rd(ADDR_CTRL3, 8'h04, 8'h04);
    wr(ADDR_CTRL3, 8'h00);
    rd(ADDR_CTRL3, 8'h04, 8'h00);
    pin_level_low = 1'b0;
    wrap_up();
  end
endmodule // tb
